//--- rtl/osu_pkg.sv
/*
  osu_pkg: constants and carrier types for the output shutdown unit.
  assumes a 25 MHz peripheral clock and a 32-bit classic wishbone slave port.
*/
package osu_pkg;
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam logic [7:0]  OFS_CTRL_STAT = 8'h00;   // control/status word
  localparam logic [7:0]  OFS_PIN_MAP   = 8'h04;   // per-pin function map
  localparam int          POS_MODE_A    = 0;
  localparam int          POS_MODE_B    = 2;
  localparam int          POS_MODE_C    = 4;
  localparam int          POS_IRQ_EN    = 8;
  localparam int          POS_FLAG_A    = 12;
  localparam int          POS_FLAG_B    = 13;
  localparam int          POS_FLAG_C    = 14;
  localparam logic [15:0] CTRL_RW_MASK  = 16'h013F;
  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  localparam logic [5:0]  PIN_MAP_RESET = 6'h3F;
  localparam int          DIV_SLOW      = 8;
  localparam int          DIV_MID       = 16;
  localparam int          DIV_FAST      = 128;
  localparam int          LOW_RUN       = 16;

  typedef enum logic [1:0] {
    MODE_EDGE, MODE_DIV8, MODE_DIV16, MODE_DIV128
  } osu_mode_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } osu_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } osu_wb_rsp_t;

  typedef struct packed {
    logic [5:0] dout;
    logic [5:0] oe;
  } osu_pins_t;
endpackage : osu_pkg

//--- rtl/osu_shutdown_guard.sv
/*
  osu_shutdown_guard: watches three active-low shutdown requests, latches
  flags, raises an interrupt and forces the phase outputs selected by the pin map off.
  assumes request inputs are asynchronous, pwm from the timer is clk-synchronous,
  standby and oscillator-halt come from the clock/power controller.
*/
// The Wishbone interface to the registers and the register addresses are this design's own decisions.
// Contract
// - any met request condition tristates the phase outputs selected by the pin map
// - two-bit mode field per input at bits 5:4, 3:2, 1:0
// - mode 00 accepts a request on a falling edge
// - edge mode reacts only to a high to low transition
// - modes 01,10,11 sample low level at clock divided by 8,16,128
// - sampling mode accepts after 16 successive low samples
// - one high sample restarts the low sample count
// - edge and level detection reach the pins with equal latency
// - accepted request sets flag bit 14, 13 or 12
// - flag clears on 0 written after read as 1; writing 1 keeps
// - interrupt while enable bit 8 and any flag are set
// - reserved bits 15, 11:9, 7:6 read zero; software writes zero
// - outputs recover only after reset or all three flags cleared
// - standby or halted oscillator also tristates the outputs
// - forcing applies only to pins mapped to gpio or timer output

// behaviour in brief:
// - every request line passes two flops; the second flop feeds both the
//   edge detector and the low-level sampler, so both paths share latency
// - the sampler divider runs free; a mode change does not restart it, so
//   the first sample after a mode write may come up to one period early
// - a level run counter restarts on any high sample and on edge mode
// - flags are sticky; a clear is armed per flag by a read that saw it set
// - a new accept always beats a clear landing in the same cycle
// - the shutdown latch releases only the cycle after all flags read zero
// - standby and a halted oscillator bypass the latch and act at once,
//   because the clock that would register them may no longer run
// - the pin map decides which phase pins may be forced; unmapped pins
//   keep driving whatever the timer gives them
// limitations:
// - no glitch filter in edge mode; a one-cycle low pulse that survives
//   the synchroniser is a valid request
// - the bus port answers every address; unmapped reads return zero
// - reserved control bits are dropped on write and read back as zero
module osu_shutdown_guard #(
  parameter int NUM_IN = 3
) (
  input  wire logic               clk,        // peripheral clock
  input  wire logic               reset_n,    // power-on reset, sync
  input  wire osu_pkg::osu_wb_req_t wbReq,    // wishbone request
  output      osu_pkg::osu_wb_rsp_t wbRsp,    // wishbone answer
  input  wire logic [NUM_IN-1:0]  reqIn_n,    // shutdown requests c,b,a
  input  wire logic               standby,    // chip in standby
  input  wire logic               oscHalted,  // oscillator stop detected
  input  wire logic [5:0]         pwmIn,      // timer phase outputs
  output      osu_pkg::osu_pins_t pins,       // phase pins, data and enable
  output      logic               irq         // interrupt request level
);
  import osu_pkg::*;

  // divider tick for a mode; edge mode ticks every cycle
  function automatic logic modeTick(input logic [1:0] m, input logic [6:0] d);
    case (m)
      2'b01:   modeTick = (d[2:0] == 3'(DIV_SLOW - 1));
      2'b10:   modeTick = (d[3:0] == 4'(DIV_MID - 1));
      2'b11:   modeTick = (d == 7'(DIV_FAST - 1));
      default: modeTick = 1'b1;
    endcase
  endfunction : modeTick

  logic [NUM_IN-1:0] sync1_r, sync2_r, prev_r, flag_r, flagRead_r;
  logic [NUM_IN-1:0] sync1_nxt, sync2_nxt, prev_nxt, flag_nxt, flagRead_nxt;
  logic [4:0]        run_r   [NUM_IN];
  logic [4:0]        run_nxt [NUM_IN];
  logic [6:0]        div_r, div_nxt;
  logic [15:0]       ctrl_r, ctrl_nxt;
  logic [5:0]        pinMap_r, pinMap_nxt;
  logic              ack_r, ack_nxt;
  logic [31:0]       rdat_r, rdat_nxt;
  logic              shut_r, shut_nxt;
  logic [NUM_IN-1:0] accept;
  logic [1:0]        mode [NUM_IN];
  logic [15:0]       ctrlView;
  logic              wbHit, wbWr, wbRd;

  // mode fields per input
  always_comb begin
    mode[0] = ctrl_r[POS_MODE_A +: 2];
    mode[1] = ctrl_r[POS_MODE_B +: 2];
    mode[2] = ctrl_r[POS_MODE_C +: 2];
  end

  // synchroniser, free-running divider, edge and low-run detection
  always_comb begin
    sync1_nxt = reqIn_n;
    sync2_nxt = sync1_r;
    prev_nxt  = sync2_r;
    div_nxt   = div_r + 7'd1;
    for (int i = 0; i < NUM_IN; i++) begin
      run_nxt[i] = run_r[i];
      accept[i]  = 1'b0;
      if (mode[i] == 2'b00) begin
        // edge decision is made in the same cycle stage as a level hit
        accept[i]  = prev_r[i] & ~sync2_r[i];
        run_nxt[i] = '0;
      end else if (modeTick(mode[i], div_r)) begin
        if (sync2_r[i]) begin
          run_nxt[i] = '0;
        end else if (run_r[i] == 5'(LOW_RUN - 1)) begin
          accept[i]  = 1'b1;
          run_nxt[i] = '0;
        end else begin
          run_nxt[i] = run_r[i] + 5'd1;
        end
      end
    end
  end

  // wishbone decode; answer one cycle after the strobe, ack drops after
  always_comb begin
    wbHit = wbReq.cyc & wbReq.stb & ~ack_r;
    wbWr  = wbHit & wbReq.we;
    wbRd  = wbHit & ~wbReq.we;
  end

  always_comb begin
    ctrlView = '0;
    ctrlView[8:0] = ctrl_r[8:0] & CTRL_RW_MASK[8:0];
    ctrlView[POS_FLAG_A] = flag_r[0];
    ctrlView[POS_FLAG_B] = flag_r[1];
    ctrlView[POS_FLAG_C] = flag_r[2];
  end

  // register file and flags; a new hit beats a clear in the same cycle
  always_comb begin
    ctrl_nxt     = ctrl_r;
    pinMap_nxt   = pinMap_r;
    flag_nxt     = flag_r;
    flagRead_nxt = flagRead_r;
    ack_nxt      = wbHit;
    rdat_nxt     = rdat_r;
    if (wbRd) begin
      case (wbReq.adr)
        OFS_CTRL_STAT: begin
          rdat_nxt     = {16'h0000, ctrlView};
          flagRead_nxt = flagRead_r | flag_r;  // arm clearing
        end
        OFS_PIN_MAP: rdat_nxt = {26'h000_0000, pinMap_r};
        default:     rdat_nxt = 32'h0000_0000;
      endcase
    end
    if (wbWr && wbReq.adr == OFS_CTRL_STAT) begin
      if (wbReq.sel[0]) begin
        ctrl_nxt[7:0] = wbReq.dat[7:0] & CTRL_RW_MASK[7:0];
      end
      if (wbReq.sel[1]) begin
        ctrl_nxt[8] = wbReq.dat[POS_IRQ_EN];
        for (int i = 0; i < NUM_IN; i++) begin
          if (flagRead_r[i] && !wbReq.dat[POS_FLAG_A + i]) begin
            flag_nxt[i]     = 1'b0;
            flagRead_nxt[i] = 1'b0;
          end
        end
      end
    end
    if (wbWr && wbReq.adr == OFS_PIN_MAP && wbReq.sel[0]) begin
      pinMap_nxt = wbReq.dat[5:0];
    end
    flag_nxt = flag_nxt | accept;
  end

  // shutdown latch: set by any accept, released only when flags are all clear
  always_comb begin
    shut_nxt = shut_r;
    if (|accept) begin
      shut_nxt = 1'b1;
    end else if (flag_r == '0) begin
      shut_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sync1_r    <= '1;
      sync2_r    <= '1;
      prev_r     <= '1;
      div_r      <= '0;
      flag_r     <= '0;
      flagRead_r <= '0;
      ctrl_r     <= CTRL_RESET;
      pinMap_r   <= PIN_MAP_RESET;
      ack_r      <= 1'b0;
      rdat_r     <= '0;
      shut_r     <= 1'b0;
      for (int i = 0; i < NUM_IN; i++) begin
        run_r[i] <= '0;
      end
    end else begin
      sync1_r    <= sync1_nxt;
      sync2_r    <= sync2_nxt;
      prev_r     <= prev_nxt;
      div_r      <= div_nxt;
      flag_r     <= flag_nxt;
      flagRead_r <= flagRead_nxt;
      ctrl_r     <= ctrl_nxt;
      pinMap_r   <= pinMap_nxt;
      ack_r      <= ack_nxt;
      rdat_r     <= rdat_nxt;
      shut_r     <= shut_nxt;
      for (int i = 0; i < NUM_IN; i++) begin
        run_r[i] <= run_nxt[i];
      end
    end
  end

  // pin drive: standby and halted clock force off without waiting a cycle
  always_comb begin
    logic force_;
    force_    = 1'b0;
    force_    = shut_r | standby | oscHalted;
    pins.dout = pwmIn;
    pins.oe   = ~(pinMap_r & {6{force_}});
    wbRsp.ack = ack_r;
    wbRsp.dat = rdat_r;
    irq       = ctrl_r[POS_IRQ_EN] & (|flag_r);
  end

  // flags: each accept sets its flag at the next edge
  flag_follows_a: assert property (@(posedge clk) disable iff (!reset_n)
    accept[0] |=> flag_r[0])
    else $error("flag a not set after accept");
  flag_b_set_a: assert property (@(posedge clk) disable iff (!reset_n)
    accept[1] |=> flag_r[1])
    else $error("flag b not set after accept");
  flag_c_set_a: assert property (@(posedge clk) disable iff (!reset_n)
    accept[2] |=> flag_r[2])
    else $error("flag c not set after accept");

  // pins: off at the edge after any accept, and still off a cycle later
  pins_off_a: assert property (@(posedge clk) disable iff (!reset_n)
    (|accept) |=> ##1 (pins.oe & pinMap_r) == 6'h00)
    else $error("pins not off");
  oe_off_next_a: assert property (@(posedge clk) disable iff (!reset_n)
    (|accept) |=> (pins.oe & pinMap_r) == 6'h00)
    else $error("pins not off one edge after accept");

  // edge mode: an accept needs a high to low step at the second flop
  edge_only_a: assert property (@(posedge clk) disable iff (!reset_n)
    (mode[0] == 2'b00 && accept[0]) |-> $past(sync2_r[0]) && !sync2_r[0])
    else $error("edge accept without fall");
  edge_b_only_a: assert property (@(posedge clk) disable iff (!reset_n)
    (mode[1] == 2'b00 && accept[1]) |-> prev_r[1] && !sync2_r[1])
    else $error("edge accept on b without fall");
  edge_c_only_a: assert property (@(posedge clk) disable iff (!reset_n)
    (mode[2] == 2'b00 && accept[2]) |-> prev_r[2] && !sync2_r[2])
    else $error("edge accept on c without fall");

  // level mode: a high sample restarts, only a full low run accepts
  run_cancel_a: assert property (@(posedge clk) disable iff (!reset_n)
    (mode[1] != 2'b00 && sync2_r[1] && modeTick(mode[1], div_r)) |=> run_r[1] == 5'd0)
    else $error("high sample did not restart count");
  run_full_a: assert property (@(posedge clk) disable iff (!reset_n)
    (mode[2] != 2'b00 && accept[2]) |-> run_r[2] == 5'(LOW_RUN - 1))
    else $error("level accept before sixteen samples");
  run_full_in_a: assert property (@(posedge clk) disable iff (!reset_n)
    (mode[0] != 2'b00 && accept[0]) |-> run_r[0] == 5'(LOW_RUN - 1))
    else $error("level accept on a before sixteen samples");
  level_low_a: assert property (@(posedge clk) disable iff (!reset_n)
    (mode[0] != 2'b00 && accept[0]) |-> !sync2_r[0])
    else $error("level accept on a high sample");
  tick_only_a: assert property (@(posedge clk) disable iff (!reset_n)
    (mode[1] != 2'b00 && !modeTick(mode[1], div_r)) |=> run_r[1] == $past(run_r[1]))
    else $error("run count moved between ticks");

  // sampling rates: a level accept only lands on its divider tick
  speed_a: assert property (@(posedge clk) disable iff (!reset_n)
    (mode[0] == 2'b01 && accept[0]) |-> div_r[2:0] == 3'(DIV_SLOW - 1))
    else $error("div8 accept off tick");
  div16_tick_a: assert property (@(posedge clk) disable iff (!reset_n)
    (mode[1] == 2'b10 && accept[1]) |-> div_r[3:0] == 4'(DIV_MID - 1))
    else $error("div16 accept off tick");
  div128_tick_a: assert property (@(posedge clk) disable iff (!reset_n)
    (mode[2] == 2'b11 && accept[2]) |-> div_r == 7'(DIV_FAST - 1))
    else $error("div128 accept off tick");

  // interrupt level follows enable and flags in the same cycle
  irq_level_a: assert property (@(posedge clk) disable iff (!reset_n)
    irq == (ctrl_r[8] && flag_r != '0))
    else $error("irq mismatch");
  irq_off_a: assert property (@(posedge clk) disable iff (!reset_n)
    !ctrl_r[POS_IRQ_EN] |-> !irq)
    else $error("irq raised while disabled");

  // reserved bits: never stored, never read back
  reserved_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
    wbRsp.ack && $past(wbRd) && $past(wbReq.adr) == OFS_CTRL_STAT
      |-> (wbRsp.dat & 32'hFFFF_8EC0) == 32'h0000_0000)
    else $error("reserved bits read nonzero");
  reserved_store_a: assert property (@(posedge clk) disable iff (!reset_n)
    ctrl_r[15:9] == 7'h00 && ctrl_r[7:6] == 2'b00)
    else $error("reserved bits stored");

  // flag clearing: armed by a read, write of one keeps the flag
  clear_needs_read_a: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(flag_r[0]) |-> $past(flagRead_r[0]))
    else $error("flag cleared unread");
  clear_b_read_a: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(flag_r[1]) |-> $past(flagRead_r[1]))
    else $error("flag b cleared unread");
  clear_c_read_a: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(flag_r[2]) |-> $past(flagRead_r[2]))
    else $error("flag c cleared unread");
  write_one_keeps_a: assert property (@(posedge clk) disable iff (!reset_n)
    (wbWr && wbReq.adr == OFS_CTRL_STAT && wbReq.sel[1] && wbReq.dat[POS_FLAG_A]
      && flag_r[0]) |=> flag_r[0])
    else $error("flag a lost on write of one");

  // release: only with every flag clear; held while any flag stands
  release_a: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(shut_r) |-> $past(flag_r) == '0)
    else $error("release with flag set");
  hold_off_a: assert property (@(posedge clk) disable iff (!reset_n)
    (shut_r && flag_r != '0) |=> shut_r)
    else $error("shutdown dropped with flag set");

  // standby, halt and pin map
  standby_off_a: assert property (@(posedge clk) disable iff (!reset_n)
    (standby || oscHalted) |-> (pins.oe & pinMap_r) == 6'h00)
    else $error("pins driven in standby");
  drive_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
    (!shut_r && !standby && !oscHalted) |-> pins.oe == 6'h3F)
    else $error("pins off without a cause");
  unmapped_kept_a: assert property (@(posedge clk) disable iff (!reset_n)
    (pins.oe | pinMap_r) == 6'h3F)
    else $error("unmapped pin forced off");

  // synchroniser depth
  sync_depth_a: assert property (@(posedge clk) disable iff (!reset_n)
    sync2_r == $past(sync1_r))
    else $error("synchroniser skipped");

  // bus: one ack per request, one cycle after it is taken
  ack_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
    wbRsp.ack |=> !wbRsp.ack)
    else $error("ack longer than one cycle");
  ack_follows_a: assert property (@(posedge clk) disable iff (!reset_n)
    (wbReq.cyc && wbReq.stb && !wbRsp.ack) |=> wbRsp.ack)
    else $error("ack missing after request");
endmodule : osu_shutdown_guard

//--- test/osu_fault_src.sv
/*
  osu_fault_src: model of the three external fault sources.
  assumes the bench calls its task after a rising clock edge.
*/
module osu_fault_src (
  input  wire logic       clk,    // peripheral clock
  output      logic [2:0] reqN    // shutdown requests c,b,a
);
  timeunit 1ns;
  timeprecision 1ps;
  // lines idle high so level mode never sees a stale low
  initial reqN = 3'h7;
  // hold one line low for a number of cycles, then release it high
  task automatic pulse(input int idx, input int lowCyc);
    reqN[idx] <= 1'b0;
    repeat (lowCyc) @(posedge clk);
    reqN[idx] <= 1'b1;
    @(posedge clk);
  endtask : pulse
endmodule : osu_fault_src

//--- test/pwm_output_shutdown_guard_tb.sv
/*
  pwm_output_shutdown_guard_tb: self-checking bench for osu_shutdown_guard.
  assumes the wishbone timing and fault source model of this folder.
*/
module pwm_output_shutdown_guard_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import osu_pkg::*;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  osu_wb_req_t wbReq = '0;
  osu_wb_rsp_t wbRsp;
  logic [2:0]  reqIn_n;
  logic        standby = 1'b0;
  logic        oscHalted = 1'b0;
  logic [5:0]  pwmIn = 6'h00;
  osu_pins_t   pins;
  logic        irq;
  logic [31:0] q;
  int          failures = 0;
  int          nTests = 0;
  int          cycles = 0;

  osu_shutdown_guard u_osu_shutdown_guard (.clk(clk), .reset_n(reset_n), .wbReq(wbReq),
    .wbRsp(wbRsp), .reqIn_n(reqIn_n), .standby(standby), .oscHalted(oscHalted),
    .pwmIn(pwmIn), .pins(pins), .irq(irq));
  osu_fault_src u_osu_fault_src (.clk(clk), .reqN(reqIn_n));

  initial begin
    forever #20 clk = ~clk;
  end
  // a hang costs a mismatch and ends the run
  always @(posedge clk) begin
    cycles++;
    if (cycles > 30000) begin
      failures++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("counts: %0d compares, %0d mismatches", nTests, failures);
    if (failures == 0 && nTests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one classic cycle; ack is read at the edge that samples it
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'h3, adr: a, dat: d};
    do @(posedge clk); while (wbRsp.ack !== 1'b1);
    q = wbRsp.dat;
    wbReq <= '0;
    @(posedge clk);
  endtask : wb
  // read, then zero only the flags seen set, ones elsewhere
  task automatic clr();
    wb(1'b0, OFS_CTRL_STAT, 0);
    wb(1'b1, OFS_CTRL_STAT, (~q & 32'h0000_7000) | (q & 32'h0000_013F));
  endtask : clr

  task automatic t_reset();
    wb(1'b0, OFS_CTRL_STAT, 0);
    chk(q, 32'h0000_0000);
    wb(1'b0, OFS_PIN_MAP, 0);
    chk(q, 32'h0000_003F);
    wb(1'b0, 8'h40, 0);
    chk(q, 32'h0000_0000);
    chk(pins.oe, 6'h3F);
    chk(irq, 1'b0);
    $display("test reset done");
  endtask : t_reset
  // edge mode on input a, write-one keeps, clear needs a prior read
  task automatic t_edge();
    wb(1'b1, OFS_CTRL_STAT, 32'h0000_0100);
    u_osu_fault_src.pulse(0, 12);
    chk(pins.oe, 6'h00);
    chk(irq, 1'b1);
    wb(1'b1, OFS_CTRL_STAT, 32'h0000_0100);
    wb(1'b0, OFS_CTRL_STAT, 0);
    chk(q, 32'h0000_1100);
    wb(1'b1, OFS_CTRL_STAT, 32'h0000_7100);
    wb(1'b0, OFS_CTRL_STAT, 0);
    chk(q, 32'h0000_1100);
    clr();
    wb(1'b0, OFS_CTRL_STAT, 0);
    chk(q, 32'h0000_0100);
    chk(pins.oe, 6'h3F);
    chk(irq, 1'b0);
    wb(1'b1, OFS_CTRL_STAT, 32'h0000_8EC0);
    wb(1'b0, OFS_CTRL_STAT, 0);
    chk(q, 32'h0000_0000);
    $display("test edge done");
  endtask : t_edge
  // sampling modes 01,10,11 on inputs a,b,c in turn
  task automatic t_level();
    int dv;
    for (int m = 1; m <= 3; m++) begin
      dv = (m == 1) ? DIV_SLOW : (m == 2) ? DIV_MID : DIV_FAST;
      wb(1'b1, OFS_CTRL_STAT, m << (2 * (m - 1)));
      u_osu_fault_src.pulse(m - 1, 10 * dv);
      repeat (2 * dv) @(posedge clk);
      u_osu_fault_src.pulse(m - 1, 10 * dv);
      wb(1'b0, OFS_CTRL_STAT, 0);
      chk(q, m << (2 * (m - 1)));
      chk(pins.oe, 6'h3F);
      u_osu_fault_src.pulse(m - 1, 17 * dv + 4);
      wb(1'b0, OFS_CTRL_STAT, 0);
      chk(q, (m << (2 * (m - 1))) | (32'h0000_0800 << m));
      chk(pins.oe, 6'h00);
      chk(irq, 1'b0);
      wb(1'b1, OFS_CTRL_STAT, 0);
      chk(pins.oe, 6'h3F);
    end
    $display("test level done");
  endtask : t_level
  // pass-through, standby, halt and the pin map
  task automatic t_pins();
    pwmIn <= 6'h2A;
    standby <= 1'b1;
    @(posedge clk);
    chk(pins.dout, 6'h2A);
    chk(pins.oe, 6'h00);
    standby <= 1'b0;
    oscHalted <= 1'b1;
    @(posedge clk);
    chk(pins.oe, 6'h00);
    oscHalted <= 1'b0;
    wb(1'b1, OFS_PIN_MAP, 32'h0000_000F);
    u_osu_fault_src.pulse(1, 6);
    chk(pins.oe, 6'h30);
    clr();
    chk(pins.oe, 6'h3F);
    $display("test pins done");
  endtask : t_pins

  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_edge();
    t_level();
    t_pins();
    wrap_up();
  end
endmodule : pwm_output_shutdown_guard_tb
